/* hdl/ivsc_map.svh */
// Purpose: Offsets, field positions, reset values for the vector/shadow block
// Assumes: Included by its bare name from design files
// Notes:   Definitions only
`ifndef IVSC_MAP_SVH
`define IVSC_MAP_SVH

// ----------------------------------------------------------------------
// Vector offset field
// ----------------------------------------------------------------------
`define IVSC_OFF_MSB        17
`define IVSC_OFF_LSB        1
`define IVSC_OFF_RESET      17'h0_0000

// ----------------------------------------------------------------------
// Priority-to-shadow map
// ----------------------------------------------------------------------
`define IVSC_PSS_FIELD_W    4
`define IVSC_PSS_SS0_BIT    0
`define IVSC_PSS_RESET      32'h0000_0000
`define IVSC_SET_DEFAULT    3'h0

// ----------------------------------------------------------------------
// Status and enables
// ----------------------------------------------------------------------
`define IVSC_STAT_RESET     8'h00
`define IVSC_EN1_LSB        27
`define IVSC_EN1_W          5
`define IVSC_EN2_W          32
`define IVSC_EN3_W          8
`define IVSC_ADC_CH         45
`define IVSC_ADDR_RESET     32'h0000_0000

`endif

/* hdl/ivsc_pkg.sv */
// Purpose: Types shared by the vector/shadow block
// Assumes: Header ivsc_map.svh supplies the numbers
// Notes:   Types only
package ivsc_pkg;

    typedef struct packed {
        logic [7:0] irq;
        logic [2:0] prio;
    } ivsc_req_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [2:0]  shadow_set;
        logic        shadow_used;
    } ivsc_vec_t;

endpackage

/* hdl/ivsc_vec_calc.sv */
// Purpose: Forms vector address and shadow set for one serviced request
// Assumes: Inputs all on the system clock
// Notes:   Pure combinational
`timescale 1ns/10ps
`include "ivsc_map.svh"

module ivsc_vec_calc
    import ivsc_pkg::*;
(
    input  wire logic [31:0]                        exception_base,
    input  wire logic [`IVSC_OFF_MSB:`IVSC_OFF_LSB] vector_offset_field,
    input  wire logic [31:0]                        priority_shadow_map_reg,
    input  wire logic [2:0]                         prio,
    input  wire logic                               single_vector,
    output      ivsc_vec_t                          vec
);
    logic [3:0]  priority_shadow_select;
    logic [31:0] off_word;

    always_comb begin
        priority_shadow_select = priority_shadow_map_reg[{prio, 2'b00} +: `IVSC_PSS_FIELD_W];
        off_word = {14'h0000, vector_offset_field, 1'b0};
        vec.addr = exception_base + off_word;
        vec.shadow_set = `IVSC_SET_DEFAULT;
        vec.shadow_used = 1'b0;
        // Reserved codes fall back to set 0
        if (!priority_shadow_select[3]) begin
            vec.shadow_set = priority_shadow_select[2:0];
        end
        if (single_vector) begin
            vec.shadow_used = priority_shadow_map_reg[`IVSC_PSS_SS0_BIT];
            if (!vec.shadow_used) begin
                vec.shadow_set = `IVSC_SET_DEFAULT;
            end
        end else begin
            vec.shadow_used = 1'b1;
        end
    end
endmodule

/* hdl/ivsc_top.sv */
// Purpose: Interrupt vector offset and shadow set control, ADC request gating
// Assumes: All inputs come from logic on clk; no pin inputs
// Notes:   Configuration reaches the block as plain ports
// Function
// - Vector start lies at per-interrupt offset bits 17:1 from exception base.
// - Every interrupt has its own independently programmable offset register.
// - Eight shadow sets (0..7); each priority has a 4-bit selection field.
// - Selection 0000..0111 picks the shadow set of that number.
// - Top-bit-set selections are reserved; default level uses shadow set 0.
// - Map bit 0 set gives single vector a shadow set, clear gives none.
// - Status low 8 bits hold the IRQ number last serviced.
// - Each ADC channel request is gated by its enable bit.
// - Channel global enable lets data-ready assert the single global ADC interrupt.
`timescale 1ns/10ps
`include "ivsc_map.svh"

module ivsc_top
    import ivsc_pkg::*;
#(
    parameter int NUM_IRQ = 256,
    parameter int ADC_CH  = `IVSC_ADC_CH
)
(
    input  wire logic                               clk,
    input  wire logic                               rst_b,
    input  wire logic                               ce,
    input  wire logic [31:0]                        exception_base,
    input  wire logic                               offset_wr,
    input  wire logic [7:0]                         offset_idx,
    input  wire logic [`IVSC_OFF_MSB:`IVSC_OFF_LSB] offset_data,
    input  wire logic                               prio_map_wr,
    input  wire logic [31:0]                        prio_map_data,
    input  wire logic                               single_vector_mode,
    input  wire logic                               service_take,
    input  wire ivsc_req_t                          service_req,
    input  wire logic [`IVSC_EN1_W-1:0]             irq_enable_reg_1,
    input  wire logic [`IVSC_EN2_W-1:0]             irq_enable_reg_2,
    input  wire logic [`IVSC_EN3_W-1:0]             irq_enable_reg_3,
    input  wire logic [ADC_CH-1:0]                  adc_global_irq_enable_reg,
    input  wire logic [ADC_CH-1:0]                  adc_ch_done,
    output      logic                               vec_valid,
    output      ivsc_vec_t                          vec_out,
    output      logic [31:0]                        priority_shadow_map_reg,
    output      logic [7:0]                         interrupt_status_reg,
    output      logic [ADC_CH-1:0]                  adc_ch_irq,
    output      logic                               adc_global_irq
);
    // ------------------------------------------------------------------
    // Offset storage
    // ------------------------------------------------------------------
    logic [`IVSC_OFF_MSB:`IVSC_OFF_LSB] per_irq_offset_reg [NUM_IRQ];
    logic [ADC_CH-1:0]                  adc_en;
    ivsc_vec_t                          vec_next;
    logic [`IVSC_OFF_MSB:`IVSC_OFF_LSB] sel_off;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_IRQ; i++) begin
                per_irq_offset_reg[i] <= `IVSC_OFF_RESET;
            end
        end else if (ce && offset_wr) begin
            per_irq_offset_reg[offset_idx] <= offset_data;
        end
    end

    // ------------------------------------------------------------------
    // Priority-to-shadow map
    // ------------------------------------------------------------------
    // Reset 0 keeps every level on set 0 until software maps it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            priority_shadow_map_reg <= `IVSC_PSS_RESET;
        end else if (ce && prio_map_wr) begin
            priority_shadow_map_reg <= prio_map_data;
        end
    end

    // ------------------------------------------------------------------
    // Vector presentation
    // ------------------------------------------------------------------
    assign sel_off = per_irq_offset_reg[service_req.irq];

    ivsc_vec_calc u_calc (
        .exception_base          (exception_base),
        .vector_offset_field     (sel_off),
        .priority_shadow_map_reg (priority_shadow_map_reg),
        .prio                    (service_req.prio),
        .single_vector           (single_vector_mode),
        .vec                     (vec_next)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vec_valid <= 1'b0;
            vec_out   <= '{addr: `IVSC_ADDR_RESET, shadow_set: `IVSC_SET_DEFAULT,
                           shadow_used: 1'b0};
        end else if (ce) begin
            vec_valid <= service_take;
            if (service_take) begin
                vec_out <= vec_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            interrupt_status_reg <= `IVSC_STAT_RESET;
        end else if (ce && service_take) begin
            interrupt_status_reg <= service_req.irq;
        end
    end

    // ------------------------------------------------------------------
    // ADC requests
    // ------------------------------------------------------------------
    // Channel order: enable 1 bits 31:27, then enable 2, then enable 3
    assign adc_en = {irq_enable_reg_3, irq_enable_reg_2, irq_enable_reg_1};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            adc_ch_irq <= '0;
        end else if (ce) begin
            adc_ch_irq <= adc_ch_done & adc_en;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            adc_global_irq <= 1'b0;
        end else if (ce) begin
            adc_global_irq <= |(adc_ch_done & adc_global_irq_enable_reg);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    vec_timing_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && service_take |=> vec_valid
            && vec_out.addr == $past(exception_base)
               + {14'h0000, $past(sel_off), 1'b0})
        else $error("vector address not base plus offset");

    // Offset bit 0 is never stored, so address bit 0 must follow the base alone
    vec_align_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && service_take |=> vec_out.addr[0] == $past(exception_base[0]))
        else $error("vector address alignment broken");

    offset_store_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && offset_wr |=> per_irq_offset_reg[$past(offset_idx)] == $past(offset_data))
        else $error("offset write not stored");

    shadow_pick_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && service_take && !single_vector_mode
            && !priority_shadow_map_reg[{service_req.prio, 2'b11}]
        |=> vec_out.shadow_used
            && vec_out.shadow_set == $past(priority_shadow_map_reg[{service_req.prio, 2'b00} +: 3]))
        else $error("shadow set not taken from map");

    shadow_rsvd_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && service_take && priority_shadow_map_reg[{service_req.prio, 2'b11}]
        |=> vec_out.shadow_set == 3'h0)
        else $error("reserved selection not on set 0");

    single_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && service_take && single_vector_mode
        |=> vec_out.shadow_used == $past(priority_shadow_map_reg[0]))
        else $error("single vector shadow use wrong");

    last_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce && service_take ##1 !(ce && service_take) [*2]
        |-> interrupt_status_reg == $past(service_req.irq, 2))
        else $error("status lost last serviced irq");

    adc_chan_a: assert property (@(posedge clk) disable iff (!rst_b)
        $past(ce) |-> adc_ch_irq == $past(adc_ch_done & adc_en))
        else $error("adc channel request not gated");

    adc_global_a: assert property (@(posedge clk) disable iff (!rst_b)
        $past(ce) |-> adc_global_irq == $past(|(adc_ch_done & adc_global_irq_enable_reg)))
        else $error("global adc irq not the OR of enabled channels");

    map_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !(ce && prio_map_wr) |=> $stable(priority_shadow_map_reg))
        else $error("shadow map changed without write");

    // Low enable must hold status, map, vec_out and vec_valid, takes and writes included
    ce_freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
        !ce |=> $stable(interrupt_status_reg) && $stable(priority_shadow_map_reg)
            && $stable(vec_out) && $stable(vec_valid))
        else $error("state changed while clock enable low");
endmodule

/* testbench/ivsc_core_model.sv */
// Purpose: Processor core stand-in that services vectored interrupts
// Assumes: Requests launched 1 ns after the rising edge of clk
// Notes:   Idle request lines show the inverse of the last request
`timescale 1ns/10ps
module ivsc_core_model
    import ivsc_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      vec_valid,
    input  wire ivsc_vec_t vec_out,
    output      logic      service_take,
    output      ivsc_req_t service_req,
    output      ivsc_vec_t got_vec,
    output      logic      got_pulse
);
    initial begin
        service_take = 1'b0;
        service_req  = '0;
        got_vec      = '0;
        got_pulse    = 1'b0;
    end
    // Answer caught one edge after the take, while it stands
    task automatic service(input logic [7:0] irq, input logic [2:0] prio);
        @(posedge clk);
        #1;
        service_take = 1'b1;
        service_req  = '{irq: irq, prio: prio};
        @(posedge clk);
        #1;
        service_take = 1'b0;
        service_req  = ~service_req;
        got_pulse    = vec_valid;
        got_vec      = vec_out;
    endtask
endmodule

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the vector offset and shadow set block
// Assumes: Inputs change 1 ns after the rising edge; ce low only in the freeze test
// Notes:   Expectations are worked out here from the field layout
`timescale 1ns/10ps
`include "ivsc_map.svh"
module tb_top
    import ivsc_pkg::*;
;
    logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1, offset_wr = 1'b0, prio_map_wr = 1'b0;
    logic        svm = 1'b0, take, vec_valid, adc_global_irq, got_pulse;
    logic [31:0] base = 32'h9D00_0000, map_data = 32'h0, map_rb;
    logic [7:0]  offset_idx = 8'h00, status, en3 = 8'h00;
    logic [16:0] offset_data = 17'h0_0000;
    logic [4:0]  en1 = 5'h00;
    logic [31:0] en2 = 32'h0;
    logic [44:0] gen = 45'h0, done = 45'h0, ch_irq;
    ivsc_req_t   req;
    ivsc_vec_t   vec_out, got_vec;
    int          fail_count = 0, compares = 0, cycles = 0;

    always #20 clk = ~clk;

    ivsc_top i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .exception_base(base),
        .offset_wr(offset_wr), .offset_idx(offset_idx), .offset_data(offset_data),
        .prio_map_wr(prio_map_wr), .prio_map_data(map_data), .single_vector_mode(svm),
        .service_take(take), .service_req(req), .irq_enable_reg_1(en1),
        .irq_enable_reg_2(en2), .irq_enable_reg_3(en3), .adc_global_irq_enable_reg(gen),
        .adc_ch_done(done), .vec_valid(vec_valid), .vec_out(vec_out),
        .priority_shadow_map_reg(map_rb), .interrupt_status_reg(status),
        .adc_ch_irq(ch_irq), .adc_global_irq(adc_global_irq));
    ivsc_core_model i_core (.clk(clk), .vec_valid(vec_valid), .vec_out(vec_out),
        .service_take(take), .service_req(req), .got_vec(got_vec), .got_pulse(got_pulse));

    task automatic report_and_stop;
        $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Hang guard, well above the under two hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("ERROR %0t timeout", $time);
            report_and_stop();
        end
    end
    task automatic chk(input logic [44:0] got, input logic [44:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_off(input logic [7:0] idx, input logic [16:0] d);
        @(posedge clk);
        #1;
        offset_wr = 1'b1;
        offset_idx = idx;
        offset_data = d;
        @(posedge clk);
        #1;
        offset_wr = 1'b0;
        offset_data = ~d;
    endtask
    task automatic wr_map(input logic [31:0] d);
        @(posedge clk);
        #1;
        prio_map_wr = 1'b1;
        map_data = d;
        @(posedge clk);
        #1;
        prio_map_wr = 1'b0;
        map_data = ~d;
        chk(map_rb, d, "map readback");
    endtask
    task automatic svc(input logic [7:0] irq, input logic [2:0] pr, input logic [31:0] ea,
                       input logic [2:0] es, input logic eu);
        i_core.service(irq, pr);
        chk(got_pulse, 1'b1, "vec_valid");
        chk(got_vec.addr, ea, "addr");
        chk(got_vec.shadow_set, es, "set");
        chk(got_vec.shadow_used, eu, "used");
        chk(status, irq, "status");
        @(posedge clk);
        #1;
        chk(vec_valid, 1'b0, "pulse end");
    endtask
    task automatic t_reset;
        chk(status, 8'h00, "status rst");
        chk(map_rb, 32'h0, "map rst");
        svc(8'h0A, 3'h3, base, 3'h0, 1'b1);
        $display("test reset done");
    endtask
    task automatic t_offsets;
        logic [7:0]  ix [3] = '{8'h00, 8'h05, 8'hFF};
        logic [16:0] ov [3] = '{17'h0_0010, 17'h1_FFFF, 17'h0_0301};
        for (int i = 0; i < 3; i++) wr_off(ix[i], ov[i]);
        for (int i = 0; i < 3; i++) svc(ix[i], 3'h0, base + {ov[i], 1'b0}, 3'h0, 1'b1);
        $display("test offsets done");
    endtask
    task automatic run_maps(input logic mode);
        logic [31:0] maps [2] = '{32'h8765_4321, 32'h0123_4560};
        logic [3:0]  f;
        svm = mode;
        foreach (maps[m]) begin
            wr_map(maps[m]);
            for (int p = 0; p < 8; p++) begin
                f = maps[m][p*4 +: 4];
                if (f[3]) f = 4'h0;
                if (mode && !maps[m][0]) f = 4'h0;
                svc(8'h05, p[2:0], base + 32'h0003_FFFE, f[2:0], !mode || maps[m][0]);
            end
        end
        svm = 1'b0;
    endtask
    task automatic t_shadow;
        run_maps(1'b0);
        $display("test shadow done");
    endtask
    task automatic t_single;
        run_maps(1'b1);
        $display("test single done");
    endtask
    // Writes, a take and ADC events while ce is low must all be ignored
    task automatic t_freeze;
        @(posedge clk);
        #1;
        ce = 1'b0;
        prio_map_wr = 1'b1;
        map_data = 32'hFFFF_FFFF;
        done = 45'h0_0000_0000_0008;
        en1 = 5'h08;
        wr_off(8'h05, 17'h0_0001);
        chk(map_rb, 32'h0123_4560, "map frozen");
        chk(ch_irq, 45'h0, "ch irq frozen");
        i_core.service(8'h33, 3'h1);
        chk(got_pulse, 1'b0, "take frozen");
        chk(status, 8'h05, "status frozen");
        prio_map_wr = 1'b0;
        done = 45'h0;
        en1 = 5'h00;
        ce = 1'b1;
        svc(8'h05, 3'h0, base + 32'h0003_FFFE, 3'h0, 1'b1);
        $display("test freeze done");
    endtask
    // Reset in mid-run clears map, status and offsets
    task automatic t_rerun;
        @(posedge clk);
        #1;
        rst_b = 1'b0;
        #1;
        chk(status, 8'h00, "status mid rst");
        chk(map_rb, 32'h0, "map mid rst");
        @(posedge clk);
        #1;
        rst_b = 1'b1;
        svc(8'h05, 3'h2, base, 3'h0, 1'b1);
        $display("test rerun done");
    endtask
    task automatic t_adc;
        int ch [7] = '{0, 4, 5, 36, 37, 44, 20};
        logic [44:0] m;
        foreach (ch[i]) begin
            m = 45'h1 << ch[i];
            {en3, en2, en1} = (i == 6) ? 45'h0 : m;
            gen = (i >= 5) ? 45'h0_0000_0010_0000 : 45'h0;
            done = m;
            @(posedge clk);
            #1;
            done = 45'h0;
            chk(ch_irq, (i == 6) ? 45'h0 : m, "ch irq");
            chk(adc_global_irq, i == 6, "global irq");
            @(posedge clk);
            #1;
            chk(ch_irq, 45'h0, "ch irq end");
        end
        $display("test adc done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_offsets();
        t_shadow();
        t_single();
        t_freeze();
        t_rerun();
        t_adc();
        report_and_stop();
    end
endmodule
